// ==== hdl/aau_addsub.sv ====
`default_nettype none
module aau_addsub
  import aau_pkg::*;
(
  input wire logic [7:0] a, // minuend or addend
  input wire logic [7:0] b, // subtrahend or addend
  input wire logic cin, // carry or borrow in
  input wire logic sub, // high for a - b - cin
  output logic [7:0] res, // 8-bit result
  output logic c, // carry out or borrow
  output logic h, // carry or borrow out of bit 3
  output logic v // two's complement overflow
);

  logic [8:0] wide;

  // one 9-bit sum covers both directions; bit 8 is carry or borrow
  always_comb begin
    if (sub) begin
      wide = {1'h0, a} - {1'h0, b} - {8'h00, cin};
    end else begin
      wide = {1'h0, a} + {1'h0, b} + {8'h00, cin};
    end
    res = wide[7:0];
    c = wide[8];
    if (sub) begin
      h = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
      v = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
    end else begin
      h = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
      v = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
    end
  end

endmodule
`default_nettype wire

// ==== hdl/aau_core.sv ====
// Chosen here: the address map and the plain strobed port.
`default_nettype none
module aau_core
  import aau_pkg::*;
(
  input wire logic clk, // core clock, 250 MHz
  input wire logic rst_b, // sync reset, active low
  input wire logic op_valid, // operation request
  input wire aau_req_type req, // operation and operands
  output logic busy, // second cycle of a two-cycle op
  output logic rsp_valid, // result pulse
  output aau_rsp_type rsp, // result and its destination
  output logic [7:0] flags, // status flags
  input wire logic [1:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata // read data, cycle after strobe
);

  typedef enum logic {aau_st_idle, aau_st_second} aau_state_type;
  aau_state_type st_q, st_d;
  aau_rsp_type rsp_q, rsp_d;
  aau_req_type hold_q, hold_d;
  logic busy_q, busy_d, rsp_valid_q, rsp_valid_d, cy_q, cy_d, fire, take;
  logic [7:0] flags_q, flags_d, rdata_q, rdata_d, lo_q, lo_d, f, r8;
  logic [7:0] add_a, add_b, add_res;
  logic add_cin, add_sub, add_c, add_h, add_v, mul_start, mul_c;
  logic [15:0] mul_prod;

  // ---------------------------------------------------------------
  // shared datapath blocks
  // ---------------------------------------------------------------
  aau_addsub u_addsub (
    .a(add_a),
    .b(add_b),
    .cin(add_cin),
    .sub(add_sub),
    .res(add_res),
    .c(add_c),
    .h(add_h),
    .v(add_v)
  );
  aau_mul u_mul (
    .clk(clk),
    .rst_b(rst_b),
    .start(mul_start),
    .a(req.dst),
    .b(req.src),
    .a_signed(req.op inside {op_smul, op_sumul, op_fsmul}),
    .b_signed(req.op inside {op_smul, op_fsmul}),
    .frac(req.op inside {op_fumul, op_fsmul}),
    .prod(mul_prod),
    .carry(mul_c)
  );
  // ---------------------------------------------------------------
  // flag helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] set_zn(input logic [7:0] fi, input logic [7:0] r);
    logic [7:0] fo;
    fo = fi;
    fo[AAU_FLAG_Z] = (r == 8'h00);
    fo[AAU_FLAG_N] = r[7];
    return fo;
  endfunction
  // logic results clear V and leave C, H and S alone
  function automatic logic [7:0] set_logic(input logic [7:0] fi, input logic [7:0] r);
    logic [7:0] fo;
    fo = set_zn(fi, r);
    fo[AAU_FLAG_V] = 1'h0;
    return fo;
  endfunction
  assign take = op_valid && (st_q == aau_st_idle);

  // ---------------------------------------------------------------
  // adder operand selection
  // ---------------------------------------------------------------
  // the high byte of a word op reuses the adder with the saved carry
  always_comb begin
    add_a = req.dst;
    add_b = req.src;
    add_cin = 1'h0;
    add_sub = 1'h0;
    if (st_q == aau_st_second) begin
      add_a = hold_q.dst_hi;
      add_b = 8'h00;
      add_cin = cy_q;
      add_sub = (hold_q.op == op_word_diff);
    end else begin
      case (req.op)
        op_carry_sum: add_cin = flags_q[AAU_FLAG_C];
        op_diff, op_borrow_diff: begin
          add_sub = 1'h1;
          add_cin = (req.op == op_borrow_diff) && flags_q[AAU_FLAG_C];
        end
        op_imm_diff, op_word_diff, op_imm_borrow_diff: begin
          add_sub = 1'h1;
          add_b = req.imm;
          add_cin = (req.op == op_imm_borrow_diff) && flags_q[AAU_FLAG_C];
        end
        op_word_sum: add_b = req.imm;
        op_negate: begin
          add_a = 8'h00;
          add_b = req.dst;
          add_sub = 1'h1;
        end
        op_plus_one, op_minus_one: begin
          add_b = AAU_ONE;
          add_sub = (req.op == op_minus_one);
        end
        default: add_b = req.src;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // sequencer, results and flags
  // ---------------------------------------------------------------
  // a flag update from an op wins over a software write in that cycle
  always_comb begin
    st_d = st_q;
    busy_d = 1'h0;
    rsp_valid_d = 1'h0;
    rsp_d = rsp_q;
    hold_d = hold_q;
    lo_d = lo_q;
    cy_d = cy_q;
    mul_start = 1'h0;
    fire = 1'h0;
    f = flags_q;
    r8 = add_res;
    flags_d = flags_q;
    if (reg_wr && reg_addr == AAU_REG_FLAGS) begin
      flags_d = reg_wdata;
    end
    case (st_q)
      aau_st_idle: begin
        if (op_valid) begin
          fire = 1'h1;
          rsp_valid_d = 1'h1;
          case (req.op)
            op_sum, op_carry_sum, op_diff, op_borrow_diff,
            op_imm_diff, op_imm_borrow_diff, op_negate: begin
              f = set_zn(flags_q, add_res);
              f[AAU_FLAG_C] = add_c;
              f[AAU_FLAG_H] = add_h;
              f[AAU_FLAG_V] = add_v;
            end
            op_plus_one, op_minus_one: begin
              f = set_zn(flags_q, add_res);
              f[AAU_FLAG_V] = add_v;
            end
            op_conj, op_test: begin
              r8 = req.dst & ((req.op == op_test) ? req.dst : req.src);
              f = set_logic(flags_q, r8);
            end
            op_imm_conj, op_clear_mask: begin
              r8 = req.dst & ((req.op == op_imm_conj) ? req.imm : AAU_ALL_ONES - req.imm);
              f = set_logic(flags_q, r8);
            end
            op_disj, op_imm_disj, op_set_mask: begin
              r8 = req.dst | ((req.op == op_disj) ? req.src : req.imm);
              f = set_logic(flags_q, r8);
            end
            op_xor: begin
              r8 = req.dst ^ req.src;
              f = set_logic(flags_q, r8);
            end
            op_invert: begin
              r8 = AAU_ALL_ONES - req.dst;
              f = set_logic(flags_q, r8);
              f[AAU_FLAG_C] = 1'h1;
            end
            op_ones: begin
              r8 = AAU_ALL_ONES;
              fire = 1'h0;
            end
            default: begin
              // word and product ops finish in the second cycle
              fire = 1'h0;
              rsp_valid_d = 1'h0;
              busy_d = 1'h1;
              hold_d = req;
              lo_d = add_res;
              cy_d = add_c;
              mul_start = aau_is_mul(req.op);
              st_d = aau_st_second;
            end
          endcase
          if (rsp_valid_d) begin
            rsp_d.dest = aau_dst_byte;
            rsp_d.value = {8'h00, r8};
          end
        end
      end
      aau_st_second: begin
        st_d = aau_st_idle;
        rsp_valid_d = 1'h1;
        fire = 1'h1;
        if (aau_is_mul(hold_q.op)) begin
          rsp_d.dest = aau_dst_prod;
          rsp_d.value = mul_prod;
          f[AAU_FLAG_Z] = (mul_prod == 16'h0000);
          f[AAU_FLAG_C] = mul_c;
        end else begin
          rsp_d.dest = aau_dst_pair;
          rsp_d.value = {add_res, lo_q};
          f[AAU_FLAG_Z] = ({add_res, lo_q} == 16'h0000);
          f[AAU_FLAG_N] = add_res[7];
          f[AAU_FLAG_V] = add_v;
          f[AAU_FLAG_C] = add_c;
          f[AAU_FLAG_S] = add_res[7] ^ add_v;
        end
      end
      default: st_d = aau_st_idle;
    endcase
    if (fire) begin
      flags_d = f;
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  // unmapped addresses and idle cycles read as zero
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        AAU_REG_FLAGS: rdata_d = flags_q;
        AAU_REG_RES_LO: rdata_d = rsp_q.value[7:0];
        AAU_REG_RES_HI: rdata_d = rsp_q.value[15:8];
        default: rdata_d = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= aau_st_idle;
      busy_q <= 1'h0;
      rsp_valid_q <= 1'h0;
      rsp_q <= '0;
      flags_q <= AAU_FLAGS_RST;
      rdata_q <= 8'h00;
      hold_q <= '0;
      lo_q <= 8'h00;
      cy_q <= 1'h0;
    end else begin
      st_q <= st_d;
      busy_q <= busy_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_q <= rsp_d;
      flags_q <= flags_d;
      rdata_q <= rdata_d;
      hold_q <= hold_d;
      lo_q <= lo_d;
      cy_q <= cy_d;
    end
  end
  assign busy = busy_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp = rsp_q;
  assign flags = flags_q;
  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_sum_value: assert property (@(posedge clk) disable iff (!rst_b)
    take && req.op == op_carry_sum |=> rsp_valid_q &&
    rsp_q.value[7:0] == 8'($past(req.dst) + $past(req.src) + $past(flags_q[AAU_FLAG_C])))
    else $error("carry sum value wrong");
  a_diff_borrow: assert property (@(posedge clk) disable iff (!rst_b)
    take && req.op == op_diff |=> flags_q[AAU_FLAG_C] == ($past(req.dst) < $past(req.src)))
    else $error("difference borrow wrong");
  a_imm_diff: assert property (@(posedge clk) disable iff (!rst_b)
    take && req.op == op_imm_diff |=> rsp_q.value[7:0] == 8'($past(req.dst) - $past(req.imm)))
    else $error("immediate difference wrong");
  a_imm_borrow: assert property (@(posedge clk) disable iff (!rst_b)
    take && req.op == op_imm_borrow_diff |=> rsp_q.value[7:0] ==
    8'($past(req.dst) - $past(req.imm) - $past(flags_q[AAU_FLAG_C])))
    else $error("immediate borrow difference wrong");
  a_word_sum: assert property (@(posedge clk) disable iff (!rst_b)
    take && req.op == op_word_sum |=> busy_q && !rsp_valid_q ##1 rsp_valid_q && !busy_q &&
    rsp_q.value == 16'($past({req.dst_hi, req.dst}, 2) + {8'h00, $past(req.imm, 2)}))
    else $error("word sum wrong");
  a_word_diff: assert property (@(posedge clk) disable iff (!rst_b)
    take && req.op == op_word_diff |-> ##2 rsp_q.dest == aau_dst_pair &&
    flags_q[AAU_FLAG_S] == (flags_q[AAU_FLAG_N] ^ flags_q[AAU_FLAG_V]))
    else $error("word difference flags wrong");
  a_conj_carry: assert property (@(posedge clk) disable iff (!rst_b)
    take && req.op inside {op_conj, op_imm_conj} |=> $stable(flags_q[AAU_FLAG_C]) &&
    !flags_q[AAU_FLAG_V])
    else $error("conjunction touched carry");
  a_disj_value: assert property (@(posedge clk) disable iff (!rst_b)
    take && req.op == op_disj |=> rsp_q.value[7:0] == ($past(req.dst) | $past(req.src)) &&
    $stable(flags_q[AAU_FLAG_H]))
    else $error("disjunction wrong");
  a_set_mask: assert property (@(posedge clk) disable iff (!rst_b)
    take && req.op == op_set_mask |=> rsp_q.value[7:0] == ($past(req.dst) | $past(req.imm)))
    else $error("set mask wrong");
  a_clear_mask: assert property (@(posedge clk) disable iff (!rst_b)
    take && req.op == op_clear_mask |=> rsp_q.value[7:0] == ($past(req.dst) & ~$past(req.imm)))
    else $error("clear mask wrong");
  a_test_keep: assert property (@(posedge clk) disable iff (!rst_b)
    take && req.op == op_test |=> rsp_q.value[7:0] == $past(req.dst) &&
    flags_q[AAU_FLAG_Z] == (rsp_q.value[7:0] == 8'h00))
    else $error("test changed value");
  a_umul_value: assert property (@(posedge clk) disable iff (!rst_b)
    take && req.op == op_umul |-> ##2 rsp_valid_q && rsp_q.dest == aau_dst_prod &&
    rsp_q.value == 16'({8'h00, $past(req.dst, 2)} * {8'h00, $past(req.src, 2)}))
    else $error("unsigned product wrong");
  a_ones_flags: assert property (@(posedge clk) disable iff (!rst_b)
    take && req.op == op_ones && !reg_wr |=> $stable(flags_q) && rsp_q.value[7:0] == AAU_ALL_ONES)
    else $error("all-ones load moved flags");
  a_xor_zero: assert property (@(posedge clk) disable iff (!rst_b)
    take && req.op == op_xor && req.dst == req.src |=> rsp_q.value[7:0] == 8'h00 &&
    flags_q[AAU_FLAG_Z])
    else $error("self xor not zero");

endmodule
`default_nettype wire

// ==== hdl/aau_mul.sv ====
`default_nettype none
module aau_mul
  import aau_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst_b, // sync reset, active low
  input wire logic start, // latch operands this edge
  input wire logic [7:0] a, // first factor
  input wire logic [7:0] b, // second factor
  input wire logic a_signed, // first factor is signed
  input wire logic b_signed, // second factor is signed
  input wire logic frac, // shift product left by one
  output logic [15:0] prod, // product, valid cycle after start
  output logic carry // bit 15 of the unshifted product
);

  logic [7:0] a_q, a_d, b_q, b_d;
  logic as_q, as_d, bs_q, bs_d, fr_q, fr_d;
  logic signed [17:0] full;
  logic [15:0] raw;

  // operand stage; the register splits the multiply over two cycles
  always_comb begin
    a_d = a_q;
    b_d = b_q;
    as_d = as_q;
    bs_d = bs_q;
    fr_d = fr_q;
    if (start) begin
      a_d = a;
      b_d = b;
      as_d = a_signed;
      bs_d = b_signed;
      fr_d = frac;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      a_q <= 8'h00;
      b_q <= 8'h00;
      as_q <= 1'h0;
      bs_q <= 1'h0;
      fr_q <= 1'h0;
    end else begin
      a_q <= a_d;
      b_q <= b_d;
      as_q <= as_d;
      bs_q <= bs_d;
      fr_q <= fr_d;
    end
  end

  // 9-bit sign extension gives one multiplier for all sign mixes
  always_comb begin
    full = $signed({as_q & a_q[7], a_q}) * $signed({bs_q & b_q[7], b_q});
    raw = full[15:0];
    carry = raw[15];
    prod = fr_q ? {raw[14:0], 1'h0} : raw;
  end

endmodule
`default_nettype wire

// ==== hdl/aau_pkg.sv ====
`default_nettype none
package aau_pkg;

  // ---------------------------------------------------------------
  // register map of the software port
  // ---------------------------------------------------------------
  localparam logic [1:0] AAU_REG_FLAGS = 2'h0;
  localparam logic [1:0] AAU_REG_RES_LO = 2'h1;
  localparam logic [1:0] AAU_REG_RES_HI = 2'h2;

  // ---------------------------------------------------------------
  // status flag positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned AAU_FLAG_C = 0;
  localparam int unsigned AAU_FLAG_Z = 1;
  localparam int unsigned AAU_FLAG_N = 2;
  localparam int unsigned AAU_FLAG_V = 3;
  localparam int unsigned AAU_FLAG_S = 4;
  localparam int unsigned AAU_FLAG_H = 5;
  localparam logic [7:0] AAU_FLAGS_RST = 8'h00;
  localparam logic [7:0] AAU_ALL_ONES = 8'hff;
  localparam logic [7:0] AAU_ONE = 8'h01;

  // ---------------------------------------------------------------
  // operations, destinations and carriers
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    op_sum, op_carry_sum, op_word_sum, op_diff, op_imm_diff,
    op_borrow_diff, op_imm_borrow_diff, op_word_diff,
    op_conj, op_imm_conj, op_disj, op_imm_disj, op_xor,
    op_invert, op_negate, op_set_mask, op_clear_mask,
    op_plus_one, op_minus_one, op_test, op_ones,
    op_umul, op_smul, op_sumul, op_fumul, op_fsmul
  } aau_op_type;

  typedef enum logic [1:0] {
    aau_dst_none, aau_dst_byte, aau_dst_pair, aau_dst_prod
  } aau_dest_type;

  typedef struct packed {
    aau_op_type op;
    logic [7:0] dst;
    logic [7:0] dst_hi;
    logic [7:0] src;
    logic [7:0] imm;
  } aau_req_type;

  typedef struct packed {
    aau_dest_type dest;
    logic [15:0] value;
  } aau_rsp_type;

  // product operations share the two-cycle path
  function automatic logic aau_is_mul(input aau_op_type op);
    return op inside {op_umul, op_smul, op_sumul, op_fumul, op_fsmul};
  endfunction

  function automatic logic aau_is_word(input aau_op_type op);
    return op inside {op_word_sum, op_word_diff};
  endfunction

endpackage
`default_nettype wire

// ==== tb/aau_rf_model.sv ====
`default_nettype none
module aau_rf_model
  import aau_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst_b, // sync reset, active low
  input wire logic issue, // bench asks for an op
  input wire aau_op_type op, // operation
  input wire logic [4:0] d_idx, // destination index
  input wire logic [4:0] s_idx, // source index
  input wire logic [7:0] imm, // constant
  input wire logic busy, // core mid two-cycle op
  input wire logic rsp_valid, // result pulse
  input wire aau_rsp_type rsp, // result
  output logic op_valid, // request
  output aau_req_type req // operands
);
  logic [7:0] rf_q [32];
  logic [4:0] wi_q;

  // operands come straight from the file, so write-backs feed later ops
  assign op_valid = issue;
  assign req = {op, rf_q[d_idx], rf_q[d_idx + 5'h01], rf_q[s_idx], imm};

  // write-back; index kept from the take since the request may move on
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wi_q <= 5'h00;
      for (int i = 0; i < 32; i++) begin
        rf_q[i] <= 8'(i * 29 + 7);
      end
    end else begin
      if (issue && !busy) begin
        wi_q <= d_idx;
      end
      if (rsp_valid && rsp.dest == aau_dst_prod) begin
        rf_q[0] <= rsp.value[7:0];
        rf_q[1] <= rsp.value[15:8];
      end else if (rsp_valid && rsp.dest != aau_dst_none) begin
        rf_q[wi_q] <= rsp.value[7:0];
        if (rsp.dest == aau_dst_pair) begin
          rf_q[wi_q + 5'h01] <= rsp.value[15:8];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`default_nettype none
module tb
  import aau_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, rst_b, issue, reg_wr, reg_rd, op_valid, busy, rsp_valid;
  aau_op_type op;
  logic [4:0] d_idx, s_idx;
  logic [7:0] imm, reg_wdata, flags, reg_rdata, ef;
  logic [1:0] reg_addr;
  logic [15:0] lv;
  aau_req_type req;
  aau_rsp_type rsp;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;

  aau_rf_model u_rf (.clk(clk), .rst_b(rst_b), .issue(issue), .op(op), .d_idx(d_idx),
    .s_idx(s_idx), .imm(imm), .busy(busy), .rsp_valid(rsp_valid), .rsp(rsp),
    .op_valid(op_valid), .req(req));
  aau_core u_dut (.clk(clk), .rst_b(rst_b), .op_valid(op_valid), .req(req), .busy(busy),
    .rsp_valid(rsp_valid), .rsp(rsp), .flags(flags), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // ----
  // compares and verdict
  // ----
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // expected {flags, value} of one op, from operands and prior flags
  function automatic logic [23:0] model(input aau_req_type r, input logic [7:0] fi);
    logic [7:0] f, a, b, y;
    logic [8:0] s9;
    logic [4:0] h5;
    logic [16:0] w;
    logic [17:0] p;
    logic [15:0] v, pw;
    logic sub, cin, ar, wd, ml;
    f = fi;
    a = r.dst;
    b = (r.op inside {op_imm_diff, op_imm_borrow_diff}) ? r.imm : r.src;
    cin = (r.op inside {op_carry_sum, op_borrow_diff, op_imm_borrow_diff}) && f[AAU_FLAG_C];
    sub = r.op inside {op_diff, op_imm_diff, op_borrow_diff, op_imm_borrow_diff, op_negate,
      op_minus_one};
    ar = sub || (r.op inside {op_sum, op_carry_sum, op_plus_one});
    wd = r.op inside {op_word_sum, op_word_diff};
    ml = r.op inside {op_umul, op_smul, op_sumul, op_fumul, op_fsmul};
    if (r.op inside {op_plus_one, op_minus_one}) b = AAU_ONE;
    if (r.op == op_negate) b = r.dst;
    if (r.op == op_negate) a = 8'h00;
    s9 = sub ? {1'b0, a} - {1'b0, b} - 9'(cin) : {1'b0, a} + {1'b0, b} + 9'(cin);
    h5 = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(cin)
      : {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(cin);
    y = s9[7:0];
    case (r.op)
      op_conj: y = a & b;
      op_imm_conj: y = a & r.imm;
      op_disj: y = a | b;
      op_imm_disj, op_set_mask: y = a | r.imm;
      op_clear_mask: y = a & (AAU_ALL_ONES - r.imm);
      op_xor: y = a ^ b;
      op_invert: y = AAU_ALL_ONES - a;
      op_test: y = a;
      op_ones: y = AAU_ALL_ONES;
      default: ;
    endcase
    v = {8'h00, y};
    if (!(wd || ml || r.op == op_ones)) begin
      f[AAU_FLAG_Z] = (y == 8'h00);
      f[AAU_FLAG_N] = y[7];
      f[AAU_FLAG_V] = ar && (sub ? (a[7] != b[7]) : (a[7] == b[7])) && (y[7] != a[7]);
    end
    if (ar && !(r.op inside {op_plus_one, op_minus_one})) begin
      f[AAU_FLAG_C] = s9[8];
      f[AAU_FLAG_H] = h5[4];
    end
    if (r.op == op_invert) f[AAU_FLAG_C] = 1'b1;
    if (wd) begin
      w = {1'b0, r.dst_hi, r.dst};
      w = (r.op == op_word_sum) ? w + 17'(r.imm) : w - 17'(r.imm);
      v = w[15:0];
      f[AAU_FLAG_Z] = (v == 16'h0000);
      f[AAU_FLAG_C] = w[16];
      f[AAU_FLAG_N] = v[15];
      f[AAU_FLAG_V] = (r.op == op_word_sum) ? (!r.dst_hi[7] && v[15]) : (r.dst_hi[7] && !v[15]);
      f[AAU_FLAG_S] = v[15] ^ f[AAU_FLAG_V];
    end
    if (ml) begin
      p = $signed({(r.op inside {op_smul, op_sumul, op_fsmul}) && a[7], a})
        * $signed({(r.op inside {op_smul, op_fsmul}) && b[7], b});
      pw = p[15:0];
      v = (r.op inside {op_fumul, op_fsmul}) ? {pw[14:0], 1'b0} : pw;
      f[AAU_FLAG_C] = pw[15];
      f[AAU_FLAG_Z] = (v == 16'h0000);
    end
    return {f, v};
  endfunction

  // ----
  // bus tasks
  // ----
  // one op; poke keeps issue high with op_ones in the busy cycle, where it must be lost
  task automatic run_op(input aau_op_type o, input logic [4:0] di, input logic [4:0] si,
      input logic [7:0] k, input logic poke);
    logic [23:0] e;
    logic two;
    aau_dest_type ed;
    two = o inside {op_word_sum, op_word_diff, op_umul, op_smul, op_sumul, op_fumul, op_fsmul};
    ed = !two ? aau_dst_byte : (o inside {op_word_sum, op_word_diff}) ? aau_dst_pair : aau_dst_prod;
    @(posedge clk);
    issue <= 1'b1;
    op <= o;
    d_idx <= di;
    s_idx <= si;
    imm <= k;
    #1;
    e = model(req, ef);
    @(posedge clk);
    issue <= poke && two;
    op <= op_ones;
    #1;
    if (two) begin
      chk_bit("busy", 1'b1, busy);
      @(posedge clk);
      issue <= 1'b0;
      #1;
    end
    chk_bit("rsp_valid", 1'b1, rsp_valid);
    chk_val("value", e[15:0], rsp.value);
    chk_val("dest", {14'h0000, ed}, {14'h0000, rsp.dest});
    chk_val("flags", {8'h00, e[23:16]}, {8'h00, flags});
    ef = e[23:16];
    lv = e[15:0];
    @(posedge clk);
    #1;
    chk_bit("pulse end", 1'b0, rsp_valid);
  endtask

  task automatic reg_write(input logic [1:0] ad, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (ad == AAU_REG_FLAGS) ef = d;
  endtask

  task automatic rd_chk(input logic [1:0] ad, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk_val("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask

  // 250 MHz core clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // hang guard; the sequence needs well under half of this
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ----
  // main sequence
  // ----
  initial begin
    {rst_b, issue, reg_wr, reg_rd, d_idx, s_idx, imm, reg_addr, reg_wdata} = '0;
    op = op_sum;
    ef = AAU_FLAGS_RST;
    lv = 16'h0000;
    void'($urandom(92));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk_val("reset flags", {8'h00, AAU_FLAGS_RST}, {8'h00, flags});
    chk_bit("reset busy", 1'b0, busy);
    for (int i = 0; i <= int'(op_fsmul); i++) begin
      run_op(aau_op_type'(i), 5'(i), 5'(i + 1), 8'h80, 1'b1);
    end
    run_op(op_xor, 5'h09, 5'h09, 8'h00, 1'b0);
    run_op(op_ones, 5'h02, 5'h00, 8'h00, 1'b0);
    run_op(op_ones, 5'h03, 5'h00, 8'h00, 1'b0);
    run_op(op_word_sum, 5'h02, 5'h00, 8'h01, 1'b0);
    reg_write(AAU_REG_RES_LO, 8'h5a);
    rd_chk(AAU_REG_RES_LO, lv[7:0]);
    rd_chk(2'h3, 8'h00);
    for (int n = 0; n < 300; n++) begin
      if ($urandom_range(0, 2) == 0) reg_write(AAU_REG_FLAGS, 8'($urandom));
      run_op(aau_op_type'($urandom_range(0, int'(op_fsmul))), 5'($urandom), 5'($urandom),
        8'($urandom), 1'($urandom));
      rd_chk(AAU_REG_FLAGS, ef);
      rd_chk(AAU_REG_RES_HI, lv[15:8]);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
